// ---- srd_pkg.sv ----
// Shared constants and types of the serial register-bank link and its host controller.
package srd_pkg;

    // Clock and serial timing of the host end.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS  = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Frame layout: address byte in bits 7..0, data byte in bits 15..8.
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS  = 8;
    localparam int ACC_BIT    = 7;
    localparam int SEL_MSB    = 6;
    localparam int SEL_LSB    = 2;
    localparam int FLAG_BIT   = 1;
    localparam int FIXED_BIT  = 0;

    // Register selects, written A6 down to A2.
    localparam int CTRL_REGS = 12;
    localparam int STAT_REGS = 7;
    localparam logic [CTRL_REGS-1:0][4:0] CTRL_SEL = {
        5'h07, 5'h03, 5'h12, 5'h02, 5'h1C, 5'h0C,
        5'h14, 5'h04, 5'h18, 5'h08, 5'h10, 5'h00};
    localparam logic [STAT_REGS-1:0][4:0] STAT_SEL = {
        5'h09, 5'h11, 5'h01, 5'h1E, 5'h0E, 5'h16, 5'h06};
    localparam logic [4:0] SEL_IDENTITY = 5'h19;

    // Control register indices in the bank (enables first).
    localparam int CTRL_ENABLE_1 = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Global status bit positions.
    localparam int GS_FRAME_ERR = 7;
    localparam int GS_LOAD_ERR  = 6;
    localparam int GS_UNDERV    = 5;
    localparam int GS_OVERV     = 4;
    localparam int GS_POR_N     = 3;
    localparam int GS_TSD       = 2;
    localparam int GS_TPW       = 1;

    // Host controller register byte offsets on AHB-Lite.
    localparam logic [7:0] HOST_TX_OFS       = 8'h00;
    localparam logic [7:0] HOST_RX_OFS       = 8'h04;
    localparam logic [7:0] HOST_STAT_OFS     = 8'h08;
    localparam logic [7:0] HOST_IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] HOST_IRQ_MASK_OFS = 8'h10;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_FAULT = 1;

    typedef enum logic [2:0] {
        H_IDLE,
        H_LEAD,
        H_SHIFT,
        H_TRAIL,
        H_GAP
    } srd_host_state_e;

endpackage

// ---- srd_link_if.sv ----
// Four-wire serial link between the host controller and the register bank.
`timescale 1ns/1ps
interface srd_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    modport device (input sclk, input cs_n, input mosi, output miso);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ---- srd_sync.sv ----
// Two-stage synchroniser for inputs arriving from outside the clock domain.
`timescale 1ns/1ps
module srd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } srd_sync_s;

    srd_sync_s st_ff;
    srd_sync_s nxt_st;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = d;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.stable;
endmodule

// ---- srd_device.sv ----
// Register bank end of the link: frame decode, control bank, sticky status and bridge gating.
//
// Notes on behaviour
// - Control access: bit7 zero reads, one writes.
// - Status access: bit7 zero reads, one clears.
// - Data byte sits in frame bits 15..8.
// - Address: access bit, select, flag, fixed one.
// - Global status bit order, D0 reserved.
// - Select codes decode to their registers.
// - Both sides enabled turns that bridge off.
// - All control registers zero after reset.
// - Only master writes change control bits.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module srd_device import srd_pkg::*; #(
    parameter logic [3:0] IDENTITY = 4'hA // Arbitrary value.
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // Serial link
    srd_link_if.device                     link,
    // Fault events from the output stages
    input  wire logic [23:0]               overcurrent_event,
    input  wire logic [23:0]               openload_event,
    input  wire logic                      undervoltage_event,
    input  wire logic                      overvoltage_event,
    input  wire logic                      tsd_event,
    input  wire logic                      tpw_event,
    // Bridge and configuration outputs
    output logic      [11:0]               high_side_on,
    output logic      [11:0]               low_side_on,
    output logic      [CTRL_REGS-1:0][7:0] ctrl_image
);
    typedef struct packed {
        logic                      sclk_d;
        logic                      cs_d;
        logic [4:0]                bit_cnt;
        logic [FRAME_BITS-1:0]     rx;
        logic [7:0]                gs_lat;
        logic [7:0]                rd_byte;
        logic                      miso;
        logic [CTRL_REGS-1:0][7:0] ctrl;
        logic [7:0]                gs;
        logic [5:0][7:0]           diag;
        logic [11:0]               hs_on;
        logic [11:0]               ls_on;
    } srd_dev_s;

    srd_dev_s st_ff;
    srd_dev_s nxt_st;
    logic     s_sclk;
    logic     s_cs_n;
    logic     s_cs;
    logic     s_mosi;

    // Link pins come from the master's domain and are synchronised first.
    srd_sync #(.W(3)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({link.sclk, ~link.cs_n, link.mosi}),
        .q       ({s_sclk, s_cs, s_mosi})
    );

    // The select travels inverted so a cleared synchroniser reads as deselected;
    // otherwise the end of reset would look like a short frame and flag an error.
    assign s_cs_n = ~s_cs;

    // Looks a select up in the control table; msb is the hit flag.
    function automatic logic [4:0] find_ctrl(input logic [4:0] sel);
        logic [4:0] r;
        r = '0;
        for (int i = 0; i < CTRL_REGS; i++) begin
            if (sel == CTRL_SEL[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Looks a select up in the status table; msb is the hit flag.
    function automatic logic [3:0] find_stat(input logic [4:0] sel);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < STAT_REGS; i++) begin
            if (sel == STAT_SEL[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // Frame engine, register bank and status flags.
    always_comb begin
        logic              rise;
        logic              fall;
        logic [15:0]       rxn;
        logic [7:0]        gs_view;
        logic [7:0]        gs_set;
        logic [7:0]        gs_clr;
        logic [5:0][7:0]   diag_set;
        logic [5:0]        diag_clr;
        logic [4:0]        chit;
        logic [3:0]        shit;
        logic [15:0]       resp;
        logic              hs;
        logic              ls;
        nxt_st   = st_ff;
        rise     = s_sclk & ~st_ff.sclk_d;
        fall     = ~s_sclk & st_ff.sclk_d;
        rxn      = {s_mosi, st_ff.rx[15:1]};
        gs_set   = '0;
        gs_clr   = '0;
        diag_clr = '0;
        chit     = '0;
        shit     = '0;
        resp     = {st_ff.rd_byte, st_ff.gs_lat};
        hs       = 1'b0;
        ls       = 1'b0;
        nxt_st.sclk_d = s_sclk;
        nxt_st.cs_d   = s_cs_n;
        // The load error bit is the live OR of the per-output flags.
        gs_view = {st_ff.gs[GS_FRAME_ERR], |st_ff.diag, st_ff.gs[GS_UNDERV:GS_TPW], 1'b0};
        for (int i = 0; i < 3; i++) begin
            diag_set[i]     = overcurrent_event[8*i +: 8];
            diag_set[i + 3] = openload_event[8*i +: 8];
        end
        gs_set[GS_UNDERV] = undervoltage_event;
        gs_set[GS_OVERV]  = overvoltage_event;
        gs_set[GS_TSD]    = tsd_event;
        gs_set[GS_TPW]    = tpw_event;

        if (st_ff.cs_d && !s_cs_n) begin
            // Frame start: the global status goes out in the first byte.
            nxt_st.bit_cnt = '0;
            nxt_st.gs_lat  = gs_view;
            nxt_st.miso    = gs_view[0];
        end else if (!s_cs_n) begin
            if (rise) begin
                nxt_st.rx = rxn;
                if (st_ff.bit_cnt != 5'h1F) begin
                    nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                end
                if (st_ff.bit_cnt == 5'(ADDR_BITS - 1)) begin
                    // Address byte complete: fetch the byte answered in bits 15..8.
                    chit = find_ctrl(rxn[ADDR_BITS + SEL_MSB:ADDR_BITS + SEL_LSB]);
                    shit = find_stat(rxn[ADDR_BITS + SEL_MSB:ADDR_BITS + SEL_LSB]);
                    if (chit[4]) begin
                        nxt_st.rd_byte = st_ff.ctrl[chit[3:0]];
                    end else if (rxn[ADDR_BITS + SEL_MSB:ADDR_BITS + SEL_LSB]
                                 == SEL_IDENTITY) begin
                        nxt_st.rd_byte = {4'h0, IDENTITY};
                    end else if (shit[3] && shit[2:0] == 3'h0) begin
                        nxt_st.rd_byte = gs_view;
                    end else if (shit[3]) begin
                        nxt_st.rd_byte = st_ff.diag[shit[2:0] - 3'h1];
                    end else begin
                        nxt_st.rd_byte = 8'h00; // Reserved selects read as zero.
                    end
                end
            end
            if (fall && st_ff.bit_cnt != 5'h00 && st_ff.bit_cnt < 5'(FRAME_BITS)) begin
                nxt_st.miso = resp[st_ff.bit_cnt[3:0]];
            end
        end else if (!st_ff.cs_d && s_cs_n) begin
            // Frame end: only a whole frame may act on the bank.
            if (st_ff.bit_cnt != 5'(FRAME_BITS)) begin
                gs_set[GS_FRAME_ERR] = 1'b1;
            end else if (st_ff.rx[FIXED_BIT] && st_ff.rx[ACC_BIT]) begin
                chit = find_ctrl(st_ff.rx[SEL_MSB:SEL_LSB]);
                shit = find_stat(st_ff.rx[SEL_MSB:SEL_LSB]);
                if (chit[4]) begin
                    // Identity and reserved selects never hit the bank.
                    nxt_st.ctrl[chit[3:0]] = st_ff.rx[15:8];
                end else if (shit[3] && shit[2:0] == 3'h0) begin
                    gs_clr = 8'hFF;
                end else if (shit[3]) begin
                    diag_clr[shit[2:0] - 3'h1] = 1'b1;
                end
            end
        end

        // A flag set in the same cycle as its clear stays set.
        nxt_st.gs = (st_ff.gs & ~gs_clr) | gs_set;
        nxt_st.gs[GS_LOAD_ERR] = 1'b0;
        nxt_st.gs[0] = 1'b0;
        nxt_st.gs[GS_POR_N] = st_ff.gs[GS_POR_N] | gs_clr[GS_POR_N];
        for (int i = 0; i < 6; i++) begin
            nxt_st.diag[i] = (diag_clr[i] ? 8'h00 : st_ff.diag[i]) | diag_set[i];
        end

        // Cross-current guard on each half-bridge.
        for (int k = 0; k < 12; k++) begin
            ls = st_ff.ctrl[CTRL_ENABLE_1 + k / 4][2 * (k % 4)];
            hs = st_ff.ctrl[CTRL_ENABLE_1 + k / 4][2 * (k % 4) + 1];
            nxt_st.hs_on[k] = hs & ~ls;
            nxt_st.ls_on[k] = ls & ~hs;
        end
    end

    // Power-on and device reset clear the whole bank.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff      <= '0;
            st_ff.ctrl <= {CTRL_REGS{CTRL_RESET}};
            st_ff.cs_d <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.miso    = st_ff.miso;
    assign high_side_on = st_ff.hs_on;
    assign low_side_on  = st_ff.ls_on;
    assign ctrl_image   = st_ff.ctrl;
endmodule

// ---- srd_host.sv ----
// Link master end: AHB-Lite command registers driving one 16-bit frame at a time.
`timescale 1ns/1ps
module srd_host import srd_pkg::*; #(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Interrupt
    output logic             irq,
    // Serial link
    srd_link_if.host         link
);
    typedef struct packed {
        srd_host_state_e state;
        logic [7:0]      div;
        logic [4:0]      bit_cnt;
        logic [15:0]     sh;
        logic [15:0]     rx;
        logic            sclk;
        logic            cs_n;
        logic            mosi;
        logic [15:0]     tx_word;
        logic [15:0]     rx_word;
        logic [1:0]      irq_stat;
        logic [1:0]      irq_mask;
        logic            irq;
        logic            wr_pend;
        logic [7:0]      wr_addr;
        logic [31:0]     hrdata;
    } srd_host_s;

    srd_host_s st_ff;
    srd_host_s nxt_st;
    logic      s_miso;

    srd_sync #(.W(1)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (link.miso),
        .q       (s_miso)
    );

    // Bus slave, frame sequencer and interrupt flags.
    always_comb begin
        logic       tick;
        logic       start;
        logic       go;
        logic [1:0] set;
        logic [1:0] clr;
        logic [3:0] nb;
        nxt_st = st_ff;
        tick   = (st_ff.div == 8'(HALF_CYC - 1));
        start  = 1'b0;
        set    = '0;
        clr    = '0;
        nb     = st_ff.bit_cnt[3:0] + 4'h1;
        go     = hsel && htrans[1] && hready;

        // Address phase: latch writes, prepare read data for the data phase.
        nxt_st.wr_pend = go && hwrite;
        nxt_st.wr_addr = haddr[7:0];
        if (go && !hwrite) begin
            case (haddr[7:0])
                HOST_TX_OFS:       nxt_st.hrdata = {16'h0000, st_ff.tx_word};
                HOST_RX_OFS:       nxt_st.hrdata = {16'h0000, st_ff.rx_word};
                HOST_STAT_OFS:     nxt_st.hrdata = {31'h0, st_ff.state != H_IDLE};
                HOST_IRQ_STAT_OFS: nxt_st.hrdata = {30'h0, st_ff.irq_stat};
                HOST_IRQ_MASK_OFS: nxt_st.hrdata = {30'h0, st_ff.irq_mask};
                default:           nxt_st.hrdata = 32'h0000_0000;
            endcase
        end

        // Data phase of a write.
        if (st_ff.wr_pend) begin
            case (st_ff.wr_addr)
                HOST_TX_OFS: begin
                    // A frame is started only when the link is idle.
                    start = (st_ff.state == H_IDLE);
                    if (start) begin
                        nxt_st.tx_word = hwdata[15:0];
                    end
                end
                HOST_IRQ_STAT_OFS: clr = hwdata[1:0];
                HOST_IRQ_MASK_OFS: nxt_st.irq_mask = hwdata[1:0];
                default: ;
            endcase
        end

        // Half-period divider runs only during a frame and the gap after it.
        if (st_ff.state == H_IDLE || tick) begin
            nxt_st.div = 8'h00;
        end else begin
            nxt_st.div = st_ff.div + 8'h01;
        end

        // Mode 0, least significant bit first: change on fall, sample on rise.
        case (st_ff.state)
            H_IDLE: begin
                if (start) begin
                    nxt_st.cs_n    = 1'b0;
                    nxt_st.mosi    = hwdata[0];
                    nxt_st.sh      = hwdata[15:0];
                    nxt_st.bit_cnt = '0;
                    nxt_st.state   = H_LEAD;
                end
            end
            H_LEAD: begin
                if (tick) begin
                    nxt_st.sclk  = 1'b1;
                    nxt_st.rx    = {s_miso, st_ff.rx[15:1]};
                    nxt_st.state = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (tick && st_ff.sclk) begin
                    nxt_st.sclk    = 1'b0;
                    nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                    if (st_ff.bit_cnt == 5'(FRAME_BITS - 1)) begin
                        nxt_st.state = H_TRAIL;
                    end else begin
                        nxt_st.mosi = st_ff.sh[nb];
                    end
                end else if (tick) begin
                    nxt_st.sclk = 1'b1;
                    nxt_st.rx   = {s_miso, st_ff.rx[15:1]};
                end
            end
            H_TRAIL: begin
                if (tick) begin
                    nxt_st.cs_n    = 1'b1;
                    nxt_st.mosi    = 1'b0;
                    nxt_st.rx_word = st_ff.rx;
                    set[IRQ_DONE]  = 1'b1;
                    // Frame or load error reported in the returned global status.
                    set[IRQ_FAULT] = st_ff.rx[GS_FRAME_ERR] | st_ff.rx[GS_LOAD_ERR];
                    nxt_st.state   = H_GAP;
                end
            end
            H_GAP: begin
                if (tick) begin
                    nxt_st.state = H_IDLE;
                end
            end
            default: nxt_st.state = H_IDLE;
        endcase

        // Sticky flags: a new event wins over a write-one clear.
        nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | set;
        nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff       <= '0;
            st_ff.state <= H_IDLE;
            st_ff.cs_n  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Zero-wait slave with an always-OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_ff.hrdata;
    assign irq       = st_ff.irq;
    assign link.sclk = st_ff.sclk;
    assign link.cs_n = st_ff.cs_n;
    assign link.mosi = st_ff.mosi;
endmodule

// ---- srd_link_asserts.sv ----
// Protocol checker for the serial link between the host end and the register bank end.
`timescale 1ns/1ps
module srd_link_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [4:0] rises_ff;
    logic [4:0] nxt_rises;
    logic       sclk_d_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Count clock rises within one frame; a deselect restarts the count.
    always_comb begin
        nxt_rises = rises_ff;
        if (cs_n) begin
            nxt_rises = 5'h00;
        end else if (sclk && !sclk_d_ff) begin
            nxt_rises = rises_ff + 5'h01;
        end
    end

    // Register the count and the delayed clock used for edge finding.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rises_ff  <= 5'h00;
            sclk_d_ff <= 1'b0;
        end else begin
            rises_ff  <= nxt_rises;
            sclk_d_ff <= sclk;
        end
    end

    // Timing follows the default half period of eight clocks.
    reset_idle_a: assert property ($fell(rst) |-> cs_n && !sclk && !mosi && !miso)
        else $error("link not idle after reset");
    idle_clock_a: assert property (cs_n |-> !sclk)
        else $error("serial clock moves while deselected");
    lead_time_a: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
        else $error("first clock rise not one half period after select");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("clock high phase has wrong length");
    low_phase_a: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("clock low phase too short");
    frame_bits_a: assert property ($rose(cs_n) |-> rises_ff == 5'h10)
        else $error("frame does not hold sixteen bits");
    tail_time_a: assert property ($fell(sclk) && rises_ff == 5'h10 |-> !cs_n [*8] ##1 cs_n)
        else $error("deselect not one half period after last bit");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("command data moves while clock is high");
    miso_hold_a: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("response data moves while clock is high");
    deselect_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("gap between frames too short");
endmodule

// ---- test_spi_register_map_decoder.sv ----
// Self-checking bench: host and register bank joined by the link, driven over AHB-Lite.
`timescale 1ns/1ps
module test_spi_register_map_decoder import srd_pkg::*;;
    logic                      ref_clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      hsel = 1'b0;
    logic [31:0]               haddr = 32'h0;
    logic [1:0]                htrans = 2'h0;
    logic                      hwrite = 1'b0;
    logic [31:0]               hwdata = 32'h0;
    logic                      hreadyout;
    logic                      hresp;
    logic [31:0]               hrdata;
    logic                      irq;
    logic [23:0]               oc_ev = 24'h0;
    logic [23:0]               ol_ev = 24'h0;
    logic [3:0]                sys_ev = 4'h0;
    logic [11:0]               hs_on;
    logic [11:0]               ls_on;
    logic [CTRL_REGS-1:0][7:0] image;
    int                        n_mismatch = 0;
    int                        checks_done = 0;
    int                        cycles = 0;

    srd_link_if srd_link_if_i ();

    srd_host srd_host_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .link(srd_link_if_i.host));

    srd_device srd_device_i (.ref_clk(ref_clk), .rst(rst), .link(srd_link_if_i.device),
        .overcurrent_event(oc_ev), .openload_event(ol_ev), .undervoltage_event(sys_ev[3]),
        .overvoltage_event(sys_ev[2]), .tsd_event(sys_ev[1]), .tpw_event(sys_ev[0]),
        .high_side_on(hs_on), .low_side_on(ls_on), .ctrl_image(image));

    srd_link_asserts srd_link_asserts_i (.ref_clk(ref_clk), .rst(rst),
        .sclk(srd_link_if_i.sclk), .cs_n(srd_link_if_i.cs_n),
        .mosi(srd_link_if_i.mosi), .miso(srd_link_if_i.miso));

    // Free-running 100 MHz clock.
    always #5 ref_clk = ~ref_clk;

    // Print the counts and the verdict, then stop.
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compare one value with its expectation; four-state so an unknown bit matches only an unknown bit.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer; entered just after a rising edge.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Send one frame, wait until the host is idle, return the in-frame response.
    task automatic xfer(input logic [15:0] frame, output logic [15:0] resp);
        logic [31:0] d;
        ahb(1'b1, HOST_TX_OFS, {16'h0, frame}, d);
        d = 32'h1;
        while (d[0] !== 1'b0) ahb(1'b0, HOST_STAT_OFS, 32'h0, d);
        ahb(1'b0, HOST_RX_OFS, 32'h0, d);
        resp = d[15:0];
        // The bank applies a write a few clocks after deselect.
        repeat (6) @(posedge ref_clk);
    endtask

    function automatic logic [15:0] fr(input logic wr, input logic [4:0] sel,
                                       input logic [7:0] data);
        return {data, wr, sel, 1'b0, 1'b1};
    endfunction

    // Stop a hung run; the limit is about three times the expected length.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            test_done();
        end
    end

    // Main sequence.
    initial begin
        logic [15:0] r;
        logic [31:0] d;
        logic [15:0] bad [4];
        logic [7:0]  gbit [4];
        gbit = '{8'h20, 8'h10, 8'h04, 8'h02};
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        // Reads carry data but must not write; everything starts at zero.
        for (int i = 0; i < CTRL_REGS; i++) begin
            xfer(fr(1'b0, CTRL_SEL[i], 8'hFF), r);
            check(r, 16'h0000);
        end
        for (int i = 0; i < CTRL_REGS; i++) begin
            xfer(fr(1'b1, CTRL_SEL[i], 8'h30 + 8'(i)), r);
            check(r[15:8], 8'h00);
        end
        for (int i = 0; i < CTRL_REGS; i++) begin
            xfer(fr(1'b0, CTRL_SEL[i], 8'h00), r);
            check(r[15:8], 8'h30 + 8'(i));
            check(image[i], 8'h30 + 8'(i));
        end
        // Identity, reserved places and a frame with its fixed bit low must change nothing.
        bad = '{fr(1'b1, SEL_IDENTITY, 8'hC3), fr(1'b1, 5'h13, 8'hC3),
                fr(1'b1, 5'h17, 8'hC3), {8'hC3, 1'b1, CTRL_SEL[0], 2'b00}};
        for (int j = 0; j < 4; j++) xfer(bad[j], r);
        xfer({8'h00, 1'b0, SEL_IDENTITY, 2'b11}, r);
        check(r[15:8], 8'h0A);
        for (int i = 0; i < CTRL_REGS; i++) check(image[i], 8'h30 + 8'(i));
        // Both sides of bridge one enabled turn it off; single sides pass through.
        xfer(fr(1'b1, CTRL_SEL[0], 8'h1B), r);
        check(hs_on[3:0], 4'h2);
        check(ls_on[3:0], 4'h4);
        xfer(fr(1'b1, CTRL_SEL[0], 8'h30), r);
        // Each flag register latches its event and is cleared by a write access.
        for (int k = 0; k < 6; k++) begin
            {ol_ev, oc_ev} <= 48'h1 << (9 * k);
            @(posedge ref_clk);
            {ol_ev, oc_ev} <= 48'h0;
            repeat (3) @(posedge ref_clk);
            xfer(fr(1'b0, STAT_SEL[k+1], 8'h00), r);
            check(r, {8'h01 << k, 8'h40});
            xfer(fr(1'b1, STAT_SEL[k+1], 8'h00), r);
            xfer(fr(1'b0, STAT_SEL[k+1], 8'h00), r);
            check(r, 16'h0000);
        end
        // Supply and thermal events, one at a time, then cleared; clearing sets the reset flag.
        for (int j = 0; j < 4; j++) begin
            sys_ev <= 4'h8 >> j;
            @(posedge ref_clk);
            sys_ev <= 4'h0;
            repeat (3) @(posedge ref_clk);
            xfer(fr(1'b0, STAT_SEL[0], 8'h00), r);
            check(r[7:0], gbit[j] | (j > 0 ? 8'h08 : 8'h00));
            xfer(fr(1'b1, STAT_SEL[0], 8'h00), r);
        end
        xfer(fr(1'b0, STAT_SEL[0], 8'h00), r);
        check(r, 16'h0808);
        for (int i = 0; i < CTRL_REGS; i++) check(image[i], 8'h30 + 8'(i));
        // Interrupts: masked stays low, unmasked rises, write of one clears.
        check(irq, 1'b0);
        ahb(1'b1, HOST_IRQ_MASK_OFS, 32'h3, d);
        @(posedge ref_clk);
        check(irq, 1'b1);
        ahb(1'b1, HOST_IRQ_STAT_OFS, 32'h3, d);
        @(posedge ref_clk);
        check(irq, 1'b0);
        oc_ev <= 24'h1;
        @(posedge ref_clk);
        oc_ev <= 24'h0;
        repeat (3) @(posedge ref_clk);
        xfer(fr(1'b0, STAT_SEL[0], 8'h00), r);
        ahb(1'b0, HOST_IRQ_STAT_OFS, 32'h0, d);
        check(d, 32'h3);
        check(irq, 1'b1);
        ahb(1'b0, 8'h20, 32'h0, d);
        check(d, 32'h0);
        check(hresp, 1'b0);
        // A second reset in mid-run returns every control register to zero.
        rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < CTRL_REGS; i++) check(image[i], 8'h00);
        check({hs_on, ls_on, irq}, 25'h0);
        test_done();
    end
endmodule
